// ### logic/sbk_pkg.sv
// package: register map, fields, reset values and types of the break logic
`default_nettype none
package sbk_pkg;
  // ------------------------------------------------------------------
  // register offsets (byte addresses)
  // ------------------------------------------------------------------
  localparam logic [7:0] SBK_OFF_TX_CTRL   = 8'h00;
  localparam logic [7:0] SBK_OFF_TX_DATA   = 8'h04;
  localparam logic [7:0] SBK_OFF_RX_STAT   = 8'h08;
  localparam logic [7:0] SBK_OFF_RX_DATA   = 8'h0c;
  localparam logic [7:0] SBK_OFF_BAUD      = 8'h10;
  localparam logic [7:0] SBK_OFF_IRQ_STAT  = 8'h14;
  localparam logic [7:0] SBK_OFF_IRQ_MASK  = 8'h18;
  // ------------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------------
  localparam int SBK_TXC_ENABLE = 0;
  localparam int SBK_TXC_BREAK  = 1;
  localparam int SBK_TXC_SRE    = 2;
  localparam int SBK_TXC_TBE    = 3;
  localparam int SBK_RXS_ENABLE = 0;
  localparam int SBK_RXS_WAKE   = 1;
  localparam int SBK_RXS_FRAME_ERR = 2;
  localparam int SBK_RXS_RDF    = 3;
  localparam int SBK_RXS_ABD    = 4;
  localparam int SBK_IRQ_TBE    = 0;
  localparam int SBK_IRQ_RX     = 1;
  localparam int SBK_IRQ_BREAK  = 2;
  localparam int SBK_IRQ_WAKE   = 3;
  localparam int SBK_IRQ_W      = 4;
  // ------------------------------------------------------------------
  // reset values and counts
  // ------------------------------------------------------------------
  localparam logic [15:0] SBK_BAUD_RST      = 16'h0000;
  localparam logic [3:0]  SBK_IRQ_MASK_RST  = 4'h0;
  localparam logic [3:0]  SBK_BREAK_ZEROS   = 4'hc;
  localparam logic [3:0]  SBK_DATA_BITS     = 4'h8;
  localparam logic [3:0]  SBK_OVERSAMPLE    = 4'hf;
  localparam logic [3:0]  SBK_MID_SAMPLE    = 4'h7;
  localparam logic [1:0]  SBK_WAKE_EDGES    = 2'h2;

  // apb request carrier
  typedef struct packed {
    logic        sel;
    logic        enable;
    logic        write;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } sbk_apb_req_t;

  typedef enum logic [3:0] {
    SBK_TX_IDLE  = 4'b0001,
    SBK_TX_START = 4'b0010,
    SBK_TX_BITS  = 4'b0100,
    SBK_TX_STOP  = 4'b1000
  } sbk_tx_state_t;
endpackage
`default_nettype wire

// ### logic/sbk_sync.sv
// two-flop synchroniser for an input pin
`default_nettype none
module sbk_sync
(
  // clock and control
  input  wire logic clk_in,
  input  wire logic srst_in,
  input  wire logic ce_in,
  // data
  input  wire logic d_in,
  output logic      q_out
);
  logic meta_reg;
  // the line idles high, so reset to one
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      meta_reg <= 1'b1;
      q_out    <= 1'b1;
    end
    else if (ce_in)
    begin
      meta_reg <= d_in;
      q_out    <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// ### logic/sbk_top.sv
// serial port with break send and break receive, apb register access
// ------------------------------------------------------------------
// Notes on behaviour
// R1: break is start bit, twelve low bit times, then stop bit
// R2: break request plus transmit enable, then data write starts break
// R3: data written with the break request is ignored, zeros sent
// R4: break request clears itself after the closing stop bit
// R5: next byte is buffered during break and sent afterwards
// R6: shift register empty flag tracks break like ordinary characters
// R7: software builds a header: break, dummy write, then sync 55h
// R8: buffer empty flag rises when data register empties
// R9: received break shows data flag, framing error, zero byte
// R10: software sets the baud generator before break detection
// R11: auto-wake counts two line edges, interrupts, then next byte
// R12: software may set auto-baud enable before sleeping
// R13: low stop sample sets framing error, byte kept anyway
// ------------------------------------------------------------------
`default_nettype none
module sbk_top
  import sbk_pkg::*;
(
  // clock, reset, enable
  input  wire logic        clk_in,
  input  wire logic        srst_in,
  input  wire logic        ce_in,
  // apb slave
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  // serial lines and interrupt
  input  wire logic        serial_receive_line_in,
  output logic             serial_transmit_line_out,
  output logic             irq_out
);
  import sbk_pkg::*;

  // ------------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------------
  sbk_apb_req_t req;
  logic         wr_acc;
  logic         rd_acc;
  logic         mapped;
  assign req = '{sel: psel_in, enable: penable_in, write: pwrite_in,
                 addr: paddr_in, wdata: pwdata_in};
  assign wr_acc = ce_in & req.sel & req.enable & req.write;
  assign rd_acc = ce_in & req.sel & req.enable & ~req.write;
  // zero wait states; a frozen block holds the bus
  assign pready_out = ce_in;
  always_comb
  begin
    case (req.addr)
      SBK_OFF_TX_CTRL, SBK_OFF_TX_DATA, SBK_OFF_RX_STAT, SBK_OFF_RX_DATA,
      SBK_OFF_BAUD, SBK_OFF_IRQ_STAT, SBK_OFF_IRQ_MASK: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end
  assign pslverr_out = req.sel & req.enable & ~mapped;

  // ------------------------------------------------------------------
  // control registers
  // ------------------------------------------------------------------
  logic        tx_en_reg;
  logic        break_req_reg;
  logic        rx_en_reg;
  logic        wake_en_reg;
  logic        abd_en_reg;
  logic [15:0] baud_reg;
  logic [3:0]  mask_reg;
  logic        break_done;
  logic        wake_done;
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      tx_en_reg     <= 1'b0;
      break_req_reg <= 1'b0;
      rx_en_reg     <= 1'b0;
      wake_en_reg   <= 1'b0;
      abd_en_reg    <= 1'b0;
      baud_reg      <= SBK_BAUD_RST;
      mask_reg      <= SBK_IRQ_MASK_RST;
    end
    else if (ce_in)
    begin
      if (wr_acc && req.addr == SBK_OFF_TX_CTRL)
      begin
        tx_en_reg     <= req.wdata[SBK_TXC_ENABLE];
        break_req_reg <= req.wdata[SBK_TXC_BREAK];
      end
      // R4: auto clear
      if (break_done)
        break_req_reg <= 1'b0;
      if (wr_acc && req.addr == SBK_OFF_RX_STAT)
      begin
        rx_en_reg   <= req.wdata[SBK_RXS_ENABLE];
        wake_en_reg <= req.wdata[SBK_RXS_WAKE];
        abd_en_reg  <= req.wdata[SBK_RXS_ABD];
      end
      if (wake_done)
        wake_en_reg <= 1'b0;
      if (wr_acc && req.addr == SBK_OFF_BAUD)
        baud_reg <= req.wdata[15:0];
      if (wr_acc && req.addr == SBK_OFF_IRQ_MASK)
        mask_reg <= req.wdata[3:0];
    end
  end

  // ------------------------------------------------------------------
  // baud tick: one per sixteenth of a bit
  // ------------------------------------------------------------------
  logic [15:0] baud_cnt_reg;
  logic        tick;
  assign tick = (baud_cnt_reg == 16'h0000);
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      baud_cnt_reg <= 16'h0000;
    else if (ce_in)
      baud_cnt_reg <= tick ? baud_reg : baud_cnt_reg - 16'h0001;
  end

  // ------------------------------------------------------------------
  // transmit buffer and shifter
  // ------------------------------------------------------------------
  logic          buf_full_reg;
  logic [7:0]    buf_data_reg;
  logic          buf_break_reg;
  sbk_tx_state_t tx_state_reg;
  logic [7:0]    tx_shift_reg;
  logic [3:0]    tx_bits_reg;
  logic [3:0]    tx_sub_reg;
  logic          tx_is_break_reg;
  logic          tx_load;
  logic          bit_end;
  logic          data_wr;
  assign data_wr  = wr_acc && req.addr == SBK_OFF_TX_DATA;
  assign tx_load  = tx_en_reg && buf_full_reg && tx_state_reg == SBK_TX_IDLE;
  assign bit_end  = tick && tx_sub_reg == SBK_OVERSAMPLE;
  assign break_done = ce_in && bit_end && tx_state_reg == SBK_TX_STOP
                      && tx_is_break_reg;

  // R5: buffer accepts the next byte while the shifter runs
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      buf_full_reg  <= 1'b0;
      buf_data_reg  <= 8'h00;
      buf_break_reg <= 1'b0;
    end
    else if (ce_in)
    begin
      if (data_wr && !buf_full_reg)
      begin
        buf_full_reg  <= 1'b1;
        buf_data_reg  <= req.wdata[7:0];
        // R2: break sampled on write; only if no break is being sent
        buf_break_reg <= break_req_reg && tx_en_reg && !tx_is_break_reg;
      end
      else if (tx_load)
        buf_full_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      tx_state_reg    <= SBK_TX_IDLE;
      tx_shift_reg    <= 8'h00;
      tx_bits_reg     <= 4'h0;
      tx_sub_reg      <= 4'h0;
      tx_is_break_reg <= 1'b0;
    end
    else if (ce_in)
    begin
      if (tick && tx_state_reg != SBK_TX_IDLE)
        tx_sub_reg <= tx_sub_reg + 4'h1;
      case (tx_state_reg)
        SBK_TX_IDLE:
          if (tx_load)
          begin
            tx_state_reg    <= SBK_TX_START;
            tx_sub_reg      <= 4'h0;
            // R3: break discards the written data
            tx_shift_reg    <= buf_break_reg ? 8'h00 : buf_data_reg;
            tx_is_break_reg <= buf_break_reg;
            // R1: twelve zero bit times for a break
            tx_bits_reg     <= buf_break_reg ? SBK_BREAK_ZEROS
                                             : SBK_DATA_BITS;
          end
        SBK_TX_START:
          if (bit_end)
            tx_state_reg <= SBK_TX_BITS;
        SBK_TX_BITS:
          if (bit_end)
          begin
            tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
            tx_bits_reg  <= tx_bits_reg - 4'h1;
            if (tx_bits_reg == 4'h1)
              tx_state_reg <= SBK_TX_STOP;
          end
        SBK_TX_STOP:
          if (bit_end)
          begin
            tx_state_reg    <= SBK_TX_IDLE;
            tx_is_break_reg <= 1'b0;
          end
        default:
          tx_state_reg <= SBK_TX_IDLE;
      endcase
    end
  end

  // line driven from a flop
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      serial_transmit_line_out <= 1'b1;
    else if (ce_in)
      serial_transmit_line_out <=
        (tx_state_reg == SBK_TX_START) ? 1'b0 :
        (tx_state_reg == SBK_TX_BITS)  ? tx_shift_reg[0] : 1'b1;
  end

  // R6: empty flag same for break and data
  logic shift_empty;
  assign shift_empty = (tx_state_reg == SBK_TX_IDLE);
  // R8: buffer empty flag
  logic buf_empty;
  assign buf_empty = ~buf_full_reg;

  // ------------------------------------------------------------------
  // receiver
  // ------------------------------------------------------------------
  logic       rx_line;
  sbk_sync u_rx_sync
  (
    .clk_in  (clk_in),
    .srst_in (srst_in),
    .ce_in   (ce_in),
    .d_in    (serial_receive_line_in),
    .q_out   (rx_line)
  );
  logic       rx_prev_reg;
  logic       rx_busy_reg;
  logic [3:0] rx_sub_reg;
  logic [3:0] rx_cnt_reg;
  logic [7:0] rx_shift_reg;
  logic [7:0] rx_data_reg;
  logic       rx_frame_err_reg;
  logic       rx_flag_reg;
  logic       rx_done;
  logic       rx_mid;
  logic [1:0] wake_edges_reg;
  logic       rx_edge;
  assign rx_edge   = rx_line ^ rx_prev_reg;
  assign rx_mid    = tick && rx_busy_reg && rx_sub_reg == SBK_MID_SAMPLE;
  assign rx_done   = rx_mid && rx_cnt_reg == 4'h9;
  // R11: two edges seen, wake event
  assign wake_done = ce_in && wake_en_reg && rx_edge
                     && wake_edges_reg == SBK_WAKE_EDGES - 2'h1;

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      rx_prev_reg    <= 1'b1;
      wake_edges_reg <= 2'h0;
    end
    else if (ce_in)
    begin
      rx_prev_reg <= rx_line;
      if (!wake_en_reg || wake_done)
        wake_edges_reg <= 2'h0;
      else if (rx_edge)
        wake_edges_reg <= wake_edges_reg + 2'h1;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      rx_busy_reg  <= 1'b0;
      rx_sub_reg   <= 4'h0;
      rx_cnt_reg   <= 4'h0;
      rx_shift_reg <= 8'h00;
    end
    else if (ce_in)
    begin
      if (!rx_busy_reg)
      begin
        if (rx_en_reg && !wake_en_reg && rx_prev_reg && !rx_line)
        begin
          rx_busy_reg <= 1'b1;
          rx_sub_reg  <= 4'h0;
          rx_cnt_reg  <= 4'h0;
        end
      end
      else if (tick)
      begin
        rx_sub_reg <= rx_sub_reg + 4'h1;
        if (rx_mid)
        begin
          rx_cnt_reg <= rx_cnt_reg + 4'h1;
          if (rx_cnt_reg == 4'h0 && rx_line)
            rx_busy_reg <= 1'b0;
          else if (rx_cnt_reg != 4'h0 && rx_cnt_reg != 4'h9)
            rx_shift_reg <= {rx_line, rx_shift_reg[7:1]};
          if (rx_done)
            rx_busy_reg <= 1'b0;
        end
      end
    end
  end

  // R9 R13: stop sample low gives framing error, byte kept
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      rx_data_reg      <= 8'h00;
      rx_frame_err_reg <= 1'b0;
      rx_flag_reg      <= 1'b0;
    end
    else if (ce_in)
    begin
      if (rx_done)
      begin
        rx_data_reg      <= rx_shift_reg;
        rx_frame_err_reg <= ~rx_line;
        rx_flag_reg      <= 1'b1;
      end
      else if (rd_acc && req.addr == SBK_OFF_RX_DATA)
      begin
        rx_flag_reg      <= 1'b0;
        rx_frame_err_reg <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // interrupts: sticky, write one to clear, set wins
  // ------------------------------------------------------------------
  logic [3:0] irq_stat_reg;
  logic [3:0] irq_set;
  logic       brk_rx;
  assign brk_rx = rx_done && !rx_line && rx_shift_reg == 8'h00;
  always_comb
  begin
    irq_set = 4'h0;
    irq_set[SBK_IRQ_TBE]   = tx_load;
    irq_set[SBK_IRQ_RX]    = rx_done;
    irq_set[SBK_IRQ_BREAK] = brk_rx;
    irq_set[SBK_IRQ_WAKE]  = wake_done;
  end
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      irq_stat_reg <= 4'h0;
    else if (ce_in)
    begin
      if (wr_acc && req.addr == SBK_OFF_IRQ_STAT)
        irq_stat_reg <= (irq_stat_reg & ~req.wdata[3:0]) | irq_set;
      else
        irq_stat_reg <= irq_stat_reg | irq_set;
    end
  end
  assign irq_out = |(irq_stat_reg & mask_reg);

  // ------------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------------
  always_comb
  begin
    prdata_out = 32'h0000_0000;
    case (req.addr)
      SBK_OFF_TX_CTRL:
      begin
        prdata_out[SBK_TXC_ENABLE] = tx_en_reg;
        prdata_out[SBK_TXC_BREAK]  = break_req_reg;
        prdata_out[SBK_TXC_SRE]    = shift_empty;
        prdata_out[SBK_TXC_TBE]    = buf_empty;
      end
      SBK_OFF_RX_STAT:
      begin
        prdata_out[SBK_RXS_ENABLE] = rx_en_reg;
        prdata_out[SBK_RXS_WAKE]   = wake_en_reg;
        prdata_out[SBK_RXS_FRAME_ERR] = rx_frame_err_reg;
        prdata_out[SBK_RXS_RDF]    = rx_flag_reg;
        prdata_out[SBK_RXS_ABD]    = abd_en_reg;
      end
      SBK_OFF_RX_DATA:  prdata_out[7:0]  = rx_data_reg;
      SBK_OFF_BAUD:     prdata_out[15:0] = baud_reg;
      SBK_OFF_IRQ_STAT: prdata_out[3:0]  = irq_stat_reg;
      SBK_OFF_IRQ_MASK: prdata_out[3:0]  = mask_reg;
      default:          prdata_out = 32'h0000_0000;
    endcase
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);

  brk_clear_a: assert property (break_done |=> !break_req_reg) // R4
    else $error("break request not cleared");
  brk_zero_a: assert property ( // R3
    ce_in && tx_load && buf_break_reg |=> tx_shift_reg == 8'h00)
    else $error("break data not zero");
  brk_len_a: assert property ( // R1
    ce_in && tx_load && buf_break_reg |=> tx_bits_reg == SBK_BREAK_ZEROS)
    else $error("break length wrong");
  sre_track_a: assert property ( // R6
    ce_in && tx_load |=> !shift_empty)
    else $error("shift empty flag stale");
  buf_empty_a: assert property ( // R8
    ce_in && tx_load && !data_wr |=> buf_empty)
    else $error("buffer empty not raised");
  buf_accept_a: assert property ( // R5
    ce_in && data_wr && buf_empty && !shift_empty |=> !buf_empty)
    else $error("byte not buffered during send");
  frame_err_a: assert property ( // R13
    ce_in && rx_done |=> rx_frame_err_reg == !$past(rx_line) && rx_flag_reg)
    else $error("framing error mismatch");
  brk_rx_a: assert property ( // R9
    ce_in && brk_rx |=> rx_data_reg == 8'h00 && rx_frame_err_reg)
    else $error("received break not shown");
  wake_irq_a: assert property ( // R11
    wake_done |=> irq_stat_reg[SBK_IRQ_WAKE] && !wake_en_reg)
    else $error("wake event lost");
  start_brk_a: assert property ( // R2
    ce_in && data_wr && buf_empty && break_req_reg && tx_en_reg
    && !tx_is_break_reg |=> buf_break_reg)
    else $error("break not armed");

  brk_send_c: cover property (break_done);
  brk_rx_c:   cover property (brk_rx);
  wake_c:     cover property (wake_done);
endmodule
`default_nettype wire

// ### verification/sbk_lin_node.sv
// far-side bus node: drives the receive line, watches the transmit line
`default_nettype none
module sbk_lin_node
(
  // clock
  input  wire logic clk_in,
  // bus lines
  input  wire logic tx_line_in,
  output logic      rx_line_out
);
  timeunit 1ns;
  timeprecision 1ns;
  int bit_clks = 16;
  initial rx_line_out = 1'b1;
  // ------------------------------------------------------------------
  // sending
  // ------------------------------------------------------------------
  // lsb first; afterwards the line is driven high for two bit times
  task automatic send_bits(input logic [15:0] bits, input int n);
    for (int i = 0; i < n; i++)
    begin
      rx_line_out <= bits[i];
      repeat (bit_clks) @(posedge clk_in);
    end
    rx_line_out <= 1'b1;
    repeat (2 * bit_clks) @(posedge clk_in);
  endtask
  // ------------------------------------------------------------------
  // watching
  // ------------------------------------------------------------------
  task automatic catch_low(output int n);
    n = 0;
    while (tx_line_in !== 1'b0) @(posedge clk_in);
    while (tx_line_in === 1'b0 && n < 4000)
    begin
      @(posedge clk_in);
      n++;
    end
  endtask
  // samples start, eight data bits and stop in mid-bit
  task automatic catch_byte(output logic [9:0] f);
    while (tx_line_in !== 1'b0) @(posedge clk_in);
    repeat (bit_clks / 2) @(posedge clk_in);
    for (int i = 0; i < 10; i++)
    begin
      f[i] = tx_line_in;
      repeat (bit_clks) @(posedge clk_in);
    end
  endtask
endmodule
`default_nettype wire

// ### verification/sbk_top_tb.sv
// self-checking bench for the break send and receive logic
`default_nettype none
module sbk_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import sbk_pkg::*;
  logic        clk     = 1'b0;
  logic        srst    = 1'b1;
  logic        ce      = 1'b1;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        rx_line;
  logic        tx_line;
  logic        irq;
  int          num_errors  = 0;
  int          checks_done = 0;
  int          baud;
  int          bc;
  int          n;
  logic [31:0] rd;
  logic        err;
  logic [9:0]  frm;
  logic [7:0]  b;
  logic        stp;

  always #25 clk = ~clk;

  sbk_top sbk_top_inst (
    .clk_in                   (clk),
    .srst_in                  (srst),
    .ce_in                    (ce),
    .psel_in                  (psel),
    .penable_in               (penable),
    .pwrite_in                (pwrite),
    .paddr_in                 (paddr),
    .pwdata_in                (pwdata),
    .prdata_out               (prdata),
    .pready_out               (pready),
    .pslverr_out              (pslverr),
    .serial_receive_line_in   (rx_line),
    .serial_transmit_line_out (tx_line),
    .irq_out                  (irq)
  );

  sbk_lin_node sbk_lin_node_inst (
    .clk_in      (clk),
    .tx_line_in  (tx_line),
    .rx_line_out (rx_line)
  );
  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  task automatic stop_test();
    if (num_errors == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // one apb transfer; an idle edge follows so psel is never set twice
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // no wait count assumed; only the watchdog ends a stuck access
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rdc(input string what, input logic [7:0] a,
                     input logic [31:0] m, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rd & m);
    chk("slverr mapped", 32'h0, {31'h0, err});
  endtask

  // polls a status bit, bounded
  task automatic wait_bit(input string what, input logic [7:0] a,
                          input int pos, input logic v);
    int k;
    k = 0;
    do
    begin
      apb(1'b0, a, 32'h0);
      k++;
    end
    while (rd[pos] !== v && k < 1000);
    chk(what, {31'h0, v}, {31'h0, rd[pos]});
  endtask

  task automatic send_byte(input logic [7:0] d, input logic s);
    sbk_lin_node_inst.send_bits({6'h3f, s, d, 1'b0}, 10);
  endtask
  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial
  begin
    void'($urandom(32'h96b73ae1));
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rdc("tx_ctrl", SBK_OFF_TX_CTRL, 32'hf, 32'hc);
    rdc("rx_stat", SBK_OFF_RX_STAT, 32'h1f, 32'h0);
    rdc("baud", SBK_OFF_BAUD, 32'hffff, {16'h0, SBK_BAUD_RST});
    rdc("irq_mask", SBK_OFF_IRQ_MASK, 32'hf, {28'h0, SBK_IRQ_MASK_RST});
    // a frozen block must hold the bus off
    ce <= 1'b0;
    @(posedge clk);
    chk("pready frozen", 32'h0, {31'h0, pready});
    ce <= 1'b1;
    @(posedge clk);
    apb(1'b1, 8'h1c, 32'hffffffff);
    chk("slverr", 32'h1, {31'h0, err});
    // break, dummy byte, then sync byte queued during the break
    baud = $urandom_range(2, 0);
    bc   = 16 * (baud + 1);
    sbk_lin_node_inst.bit_clks = bc;
    apb(1'b1, SBK_OFF_BAUD, baud);
    apb(1'b1, SBK_OFF_TX_CTRL, 32'h3);
    fork
      begin
        sbk_lin_node_inst.catch_low(n);
        sbk_lin_node_inst.catch_byte(frm);
      end
      begin
        apb(1'b1, SBK_OFF_TX_DATA, $urandom_range(255, 1));
        wait_bit("buffer empty", SBK_OFF_TX_CTRL, SBK_TXC_TBE, 1'b1);
        apb(1'b1, SBK_OFF_TX_DATA, 32'h55);
        rdc("tx_ctrl busy", SBK_OFF_TX_CTRL, 32'hf, 32'h3);
      end
    join
    chk("break bits", 32'd13, (n + bc / 2) / bc);
    chk("sync frame", 32'h2aa, {22'h0, frm});
    wait_bit("shift empty", SBK_OFF_TX_CTRL, SBK_TXC_SRE, 1'b1);
    rdc("tx_ctrl done", SBK_OFF_TX_CTRL, 32'hf, 32'hd);
    rdc("tbe irq", SBK_OFF_IRQ_STAT, 32'h1, 32'h1);
    apb(1'b1, SBK_OFF_IRQ_STAT, 32'h1);
    rdc("tbe irq clr", SBK_OFF_IRQ_STAT, 32'h1, 32'h0);
    // random bytes, good and bad stop bits
    apb(1'b1, SBK_OFF_RX_STAT, 32'h1);
    for (int i = 0; i < 4; i++)
    begin
      b   = 8'($urandom);
      stp = i[0];
      send_byte(b, stp);
      wait_bit("data flag", SBK_OFF_RX_STAT, SBK_RXS_RDF, 1'b1);
      chk("framing err", {31'h0, ~stp}, {31'h0, rd[SBK_RXS_FRAME_ERR]});
      rdc("rx byte", SBK_OFF_RX_DATA, 32'hff, {24'h0, b});
    end
    // break arriving on the receive line
    sbk_lin_node_inst.send_bits(16'h0000, 13);
    wait_bit("break flag", SBK_OFF_RX_STAT, SBK_RXS_RDF, 1'b1);
    chk("break frame err", 32'h1, {31'h0, rd[SBK_RXS_FRAME_ERR]});
    rdc("break byte", SBK_OFF_RX_DATA, 32'hff, 32'h0);
    rdc("break irq", SBK_OFF_IRQ_STAT, 32'h4, 32'h4);
    chk("irq masked", 32'h0, {31'h0, irq});
    apb(1'b1, SBK_OFF_IRQ_MASK, 32'h4);
    chk("irq on", 32'h1, {31'h0, irq});
    apb(1'b1, SBK_OFF_IRQ_STAT, 32'hf);
    chk("irq off", 32'h0, {31'h0, irq});
    // auto-wake: two edges, then the next byte
    apb(1'b1, SBK_OFF_RX_STAT, 32'h13);
    rdc("autobaud", SBK_OFF_RX_STAT, 32'h10, 32'h10);
    sbk_lin_node_inst.send_bits(16'h0000, 13);
    rdc("wake irq", SBK_OFF_IRQ_STAT, 32'ha, 32'h8);
    rdc("wake off", SBK_OFF_RX_STAT, 32'h2, 32'h0);
    b = 8'($urandom);
    send_byte(b, 1'b1);
    wait_bit("wake data", SBK_OFF_RX_STAT, SBK_RXS_RDF, 1'b1);
    rdc("wake byte", SBK_OFF_RX_DATA, 32'hff, {24'h0, b});
    rdc("wake rx irq", SBK_OFF_IRQ_STAT, 32'h2, 32'h2);
    stop_test();
  end

  // hang guard, well beyond the longest expected run
  initial
  begin
    repeat (60000) @(posedge clk);
    num_errors++;
    stop_test();
  end
endmodule
`default_nettype wire
